// File: roc_ctrl.sv
`timescale 1ns/1ps
module roc_ctrl #(
  parameter int WORD_W = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Processor request stream
  input wire logic pr_valid,
  output logic pr_ready,
  input wire logic pr_first,
  input wire logic pr_last,
  input wire logic pr_write,
  input wire logic [roc_pkg::ADDR_W-1:0] pr_addr,
  input wire logic [WORD_W-1:0] pr_data,
  // Processor response
  output logic rsp_valid,
  output logic [WORD_W-1:0] rsp_data,
  // Outgoing FIFO
  output logic out_valid,
  input wire logic out_ready,
  output logic out_header,
  output logic out_last,
  output logic out_write,
  output logic [WORD_W-1:0] out_word,
  // Local bus
  output logic lb_valid,
  input wire logic lb_ready,
  output logic lb_first,
  output logic lb_last,
  output logic lb_write,
  output logic [WORD_W-1:0] lb_word,
  input wire logic lb_rsp_valid,
  output logic lb_rsp_ready,
  input wire logic [WORD_W-1:0] lb_rsp_data,
  // Incoming FIFO and delivery to processor
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WORD_W-1:0] in_word,
  input wire logic in_perr,
  output logic cpu_in_valid,
  input wire logic cpu_in_ready,
  output logic [WORD_W-1:0] cpu_in_word,
  output logic parity_irq,
  // Station strap and status
  input wire logic [roc_pkg::SRC_W-1:0] src_route_pin,
  output logic fifo_enabled,
  output logic parity_check_on,
  output logic override_enable_flag,
  output logic [7:0] routing_override_mask
);
  if (WORD_W != 64) begin : g_bad_width
    $error("roc_ctrl supports only 64-bit words");
  end
  roc_pkg::roc_dest_t dest_ff, hdr_dest, cur_dest;
  logic fifo_en_ff, par_en_ff, ovr_ff;
  logic [1:0] sel_ff, fn;
  logic ena_ff, wr_ff, ov_ff, ov_lb_ff, ohdr_ff, olast_ff, owr_ff;
  logic rsp_v_ff, ib_v_ff, irq_ff;
  logic [WORD_W-1:0] oword_ff, rsp_d_ff, ib_word_ff, out_addr;
  logic [roc_pkg::SRC_W-1:0] src_s1_ff, src_ff;
  logic [3:0] magic;
  logic [7:0] mask_ff, route, wr_byte;
  logic use_mask, take, hdr_take, oreg_free, ctrl_rd, ctrl_wr, pop;
  assign magic = pr_addr[roc_pkg::MAGIC_MSB:roc_pkg::MAGIC_LSB];
  assign fn = pr_addr[roc_pkg::FN_MSB:roc_pkg::FN_LSB];
  assign wr_byte = pr_data[roc_pkg::ROUTE_MSB:roc_pkg::ROUTE_LSB];
  // Destination decode of a header beat
  always_comb begin
    if (magic != roc_pkg::MAGIC_PROC) begin
      hdr_dest = roc_pkg::DST_OUT;
    end else if (fn == roc_pkg::FN_LBUS) begin
      hdr_dest = roc_pkg::DST_LB;
    end else begin
      hdr_dest = roc_pkg::DST_CTRL;
    end
    cur_dest = pr_first ? hdr_dest : dest_ff;
  end
  assign oreg_free = !ov_ff || (ov_lb_ff ? lb_ready : out_ready);
  assign pr_ready = (cur_dest == roc_pkg::DST_CTRL) || oreg_free;
  assign take = pr_valid && pr_ready;
  assign hdr_take = take && pr_first;
  assign ctrl_rd = hdr_take && hdr_dest == roc_pkg::DST_CTRL && !pr_write;
  assign ctrl_wr = take && !pr_first && dest_ff == roc_pkg::DST_CTRL && wr_ff &&
                   sel_ff != roc_pkg::FN_INTR;
  roc_route_sel u_route (
    .station(pr_addr[roc_pkg::STN_MSB:roc_pkg::STN_LSB]),
    .magic(magic),
    .fn_hi(pr_addr[roc_pkg::FN_MSB]),
    .ovr_en(ovr_ff),
    .mask(mask_ff),
    .route(route),
    .use_mask(use_mask)
  );
  // Source bits always from the strap, never from the mask
  assign out_addr = {src_ff, 4'h0, route, pr_addr};
  // Strap synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_s1_ff <= '0;
      src_ff <= '0;
    end else begin
      src_s1_ff <= src_route_pin;
      src_ff <= src_s1_ff;
    end
  end
  // Packet tracking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dest_ff <= roc_pkg::DST_OUT;
      sel_ff <= roc_pkg::FN_FIFO;
      ena_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else if (hdr_take) begin
      dest_ff <= hdr_dest;
      sel_ff <= fn;
      ena_ff <= pr_addr[roc_pkg::ENA_BIT];
      wr_ff <= pr_write;
    end
  end
  // Control state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_en_ff <= roc_pkg::FIFO_EN_RST;
      par_en_ff <= roc_pkg::PAR_EN_RST;
      ovr_ff <= roc_pkg::OVR_RST;
      mask_ff <= roc_pkg::MASK_RST;
    end else if (ctrl_rd) begin
      if (fn == roc_pkg::FN_FIFO) begin
        fifo_en_ff <= 1'b0;
      end
      if (fn == roc_pkg::FN_PARITY) begin
        par_en_ff <= 1'b0;
      end
    end else if (ctrl_wr) begin
      mask_ff <= wr_byte;
      ovr_ff <= ena_ff;
      if (sel_ff == roc_pkg::FN_FIFO) begin
        fifo_en_ff <= 1'b1;
      end else begin
        par_en_ff <= 1'b1;
      end
    end
  end
  // Output register shared by outgoing FIFO and local bus
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ov_ff <= 1'b0;
      ov_lb_ff <= 1'b0;
      ohdr_ff <= 1'b0;
      olast_ff <= 1'b0;
      owr_ff <= 1'b0;
      oword_ff <= '0;
    end else if (take && cur_dest != roc_pkg::DST_CTRL) begin
      ov_ff <= 1'b1;
      ov_lb_ff <= cur_dest == roc_pkg::DST_LB;
      ohdr_ff <= pr_first;
      olast_ff <= pr_last;
      owr_ff <= pr_first ? pr_write : wr_ff;
      if (!pr_first) begin
        oword_ff <= pr_data;
      end else if (hdr_dest == roc_pkg::DST_LB) begin
        oword_ff <= {{(WORD_W-roc_pkg::ADDR_W){1'b0}}, pr_addr};
      end else begin
        oword_ff <= out_addr;
      end
    end else if (oreg_free) begin
      ov_ff <= 1'b0;
    end
  end
  assign out_valid = ov_ff && !ov_lb_ff;
  assign lb_valid = ov_ff && ov_lb_ff;
  assign out_header = ohdr_ff;
  assign lb_first = ohdr_ff;
  assign out_last = olast_ff;
  assign lb_last = olast_ff;
  assign out_write = owr_ff;
  assign lb_write = owr_ff;
  assign out_word = oword_ff;
  assign lb_word = oword_ff;
  // Responses; control writes give none
  assign lb_rsp_ready = !ctrl_rd;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= '0;
    end else begin
      rsp_v_ff <= ctrl_rd || lb_rsp_valid && lb_rsp_ready;
      rsp_d_ff <= ctrl_rd ? '0 : lb_rsp_data;
    end
  end
  assign rsp_valid = rsp_v_ff;
  assign rsp_data = rsp_d_ff;
  // Incoming path, stalled while disabled
  assign cpu_in_valid = ib_v_ff && fifo_en_ff;
  assign pop = cpu_in_valid && cpu_in_ready;
  assign in_ready = fifo_en_ff && (!ib_v_ff || pop);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ib_v_ff <= 1'b0;
      ib_word_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        ib_v_ff <= 1'b1;
        ib_word_ff <= in_word;
      end else if (pop) begin
        ib_v_ff <= 1'b0;
      end
      irq_ff <= in_valid && in_ready && in_perr && par_en_ff;
    end
  end
  assign cpu_in_word = ib_word_ff;
  assign parity_irq = irq_ff;
  assign fifo_enabled = fifo_en_ff;
  assign parity_check_on = par_en_ff;
  assign override_enable_flag = ovr_ff;
  assign routing_override_mask = mask_ff;
  // Checks
  sequence s_fifo_off_rd;
    ctrl_rd && fn == roc_pkg::FN_FIFO;
  endsequence
  sequence s_ack;
    rsp_valid && rsp_data == '0;
  endsequence
  property p_fifo_off;
    @(posedge clk) disable iff (reset) s_fifo_off_rd |=> s_ack and !fifo_enabled;
  endproperty
  a_fifo_off: assert property (p_fifo_off) else $error("fifo disable read");
  property p_stall;
    @(posedge clk) disable iff (reset) !fifo_enabled |-> !in_ready && !cpu_in_valid;
  endproperty
  a_stall: assert property (p_stall) else $error("incoming not stalled");
  property p_mask_load;
    @(posedge clk) disable iff (reset)
      ctrl_wr |=> routing_override_mask == $past(wr_byte) &&
      override_enable_flag == $past(ena_ff);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");
  property p_fifo_on;
    @(posedge clk) disable iff (reset)
      ctrl_wr && sel_ff == roc_pkg::FN_FIFO |=> fifo_enabled;
  endproperty
  a_fifo_on: assert property (p_fifo_on) else $error("fifo not re-enabled");
  property p_par_on;
    @(posedge clk) disable iff (reset)
      ctrl_wr && sel_ff == roc_pkg::FN_PARITY |=> parity_check_on &&
      fifo_enabled == $past(fifo_en_ff);
  endproperty
  a_par_on: assert property (p_par_on) else $error("parity write effect");
  property p_par_off;
    @(posedge clk) disable iff (reset)
      ctrl_rd && fn == roc_pkg::FN_PARITY |=> !parity_check_on ##1 !parity_irq;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity not off");
  property p_override;
    @(posedge clk) disable iff (reset)
      hdr_take && hdr_dest == roc_pkg::DST_OUT && ovr_ff && magic == roc_pkg::MAGIC_MEM
      |=> out_word[roc_pkg::ROUTE_MSB:roc_pkg::ROUTE_LSB] == $past(mask_ff);
  endproperty
  a_override: assert property (p_override) else $error("mask not substituted");
  property p_src;
    @(posedge clk) disable iff (reset)
      out_valid && out_header |-> out_word[roc_pkg::SRC_MSB:roc_pkg::SRC_LSB] == src_ff;
  endproperty
  a_src: assert property (p_src) else $error("source bits changed");
  property p_lbus;
    @(posedge clk) disable iff (reset)
      hdr_take && hdr_dest == roc_pkg::DST_LB |=> lb_valid && lb_first;
  endproperty
  a_lbus: assert property (p_lbus) else $error("local bus not forwarded");
  property p_remote_mask;
    @(posedge clk) disable iff (reset) hdr_take && magic == roc_pkg::MAGIC_REMOTE && fn[1]
      |-> use_mask ##1 out_word[roc_pkg::ROUTE_MSB:roc_pkg::ROUTE_LSB] == $past(mask_ff);
  endproperty
  a_remote_mask: assert property (p_remote_mask) else $error("remote mask not used");
endmodule

// File: roc_far.sv
`timescale 1ns/1ps
module roc_far (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Outgoing FIFO and local bus
  output logic out_ready,
  output logic lb_ready,
  input wire logic lb_valid,
  input wire logic lb_first,
  input wire logic lb_write,
  output logic lb_rsp_valid,
  input wire logic lb_rsp_ready,
  output logic [63:0] lb_rsp_data,
  // Incoming FIFO and processor
  output logic in_valid,
  input wire logic in_ready,
  output logic [63:0] in_word,
  output logic in_perr,
  output logic cpu_in_ready
);
  localparam logic [63:0] LB_DATA = 64'h5A5A_0000_1234_C3C3;
  // Sinks stall at random
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_ready <= 1'b0;
      lb_ready <= 1'b0;
      cpu_in_ready <= 1'b0;
    end else begin
      out_ready <= ($urandom_range(3) != 0);
      lb_ready <= ($urandom_range(3) != 0);
      cpu_in_ready <= ($urandom_range(3) != 0);
    end
  end
  // Local bus answers a read one cycle after its header
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lb_rsp_valid <= 1'b0;
      lb_rsp_data <= 64'h0;
    end else if (lb_valid && lb_ready && lb_first && !lb_write) begin
      lb_rsp_valid <= 1'b1;
      lb_rsp_data <= LB_DATA;
    end else if (lb_rsp_valid && lb_rsp_ready) begin
      lb_rsp_valid <= 1'b0;
      lb_rsp_data <= ~LB_DATA;
    end
  end
  // Incoming source always full, every other word has a parity error
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_valid <= 1'b0;
      in_word <= 64'h0;
      in_perr <= 1'b0;
    end else begin
      in_valid <= 1'b1;
      if (in_valid && in_ready) begin
        in_word <= in_word + 64'h1;
        in_perr <= ~in_perr;
      end
    end
  end
endmodule

// File: roc_pkg.sv
package roc_pkg;
  // Address fields of a processor request
  localparam int ADDR_W = 40;
  localparam int MAGIC_MSB = 35;
  localparam int MAGIC_LSB = 32;
  localparam int FN_MSB = 27;
  localparam int FN_LSB = 26;
  localparam int ENA_BIT = 25;
  localparam int STN_MSB = 39;
  localparam int STN_LSB = 36;
  // Outgoing header word fields
  localparam int ROUTE_MSB = 47;
  localparam int ROUTE_LSB = 40;
  localparam int SRC_MSB = 63;
  localparam int SRC_LSB = 52;
  localparam int SRC_W = 12;
  localparam int ROUTE_W = 8;
  // Selector and function codes
  localparam logic [3:0] MAGIC_PROC = 4'h1;
  localparam logic [3:0] MAGIC_MEM = 4'hF;
  localparam logic [3:0] MAGIC_REMOTE = 4'h8;
  localparam logic [1:0] FN_FIFO = 2'h0;
  localparam logic [1:0] FN_PARITY = 2'h1;
  localparam logic [1:0] FN_INTR = 2'h2;
  localparam logic [1:0] FN_LBUS = 2'h3;
  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic OVR_RST = 1'b0;
  localparam logic FIFO_EN_RST = 1'b1;
  localparam logic PAR_EN_RST = 1'b1;
  // Where the beats of the current packet go
  typedef enum logic [1:0] {DST_OUT, DST_LB, DST_CTRL} roc_dest_t;
endpackage

// File: roc_route_sel.sv
`timescale 1ns/1ps
module roc_route_sel (
  // Request fields
  input wire logic [3:0] station,
  input wire logic [3:0] magic,
  input wire logic fn_hi,
  // Override state
  input wire logic ovr_en,
  input wire logic [7:0] mask,
  // Routing byte
  output logic [7:0] route,
  output logic use_mask
);
  logic [7:0] auto_route;

  always_comb begin
    auto_route = 8'h00;
    auto_route[{1'b1, station[3:2]}] = 1'b1;
    auto_route[{1'b0, station[1:0]}] = 1'b1;
    use_mask = (ovr_en && magic == roc_pkg::MAGIC_MEM) ||
               (magic == roc_pkg::MAGIC_REMOTE && fn_hi);
    route = use_mask ? mask : auto_route;
  end
endmodule

// File: routing_override_control_tb.sv
`timescale 1ns/1ps
module routing_override_control_tb;
  logic clk = 0, reset = 1, pr_valid = 0, pr_first = 0, pr_last = 0, pr_write = 0;
  logic [39:0] pr_addr = '0, a;
  logic [63:0] pr_data = '0;
  logic [11:0] src_route_pin = 12'h000;
  logic pr_ready, rsp_valid, out_valid, out_ready, out_header, out_last, out_write;
  logic lb_valid, lb_ready, lb_first, lb_last, lb_write, lb_rsp_valid, lb_rsp_ready;
  logic in_valid, in_ready, in_perr, cpu_in_valid, cpu_in_ready, parity_irq;
  logic fifo_enabled, parity_check_on, override_enable_flag, flag_e = 0;
  logic [7:0] routing_override_mask, mask_e = 8'h00;
  logic [63:0] rsp_data, out_word, lb_word, lb_rsp_data, in_word, cpu_in_word;
  logic [63:0] exp_q[$];
  logic [3:0] sels[4] = '{4'hF, 4'h8, 4'h2, 4'hF};
  int num_errors = 0, checked = 0, cyc = 0, rsp_n = 0, irq_n = 0, dlv_n = 0, k, j, e, i;
  always #10 clk = ~clk;
  roc_ctrl DUT (.clk, .reset, .pr_valid, .pr_ready, .pr_first, .pr_last, .pr_write,
    .pr_addr, .pr_data, .rsp_valid, .rsp_data, .out_valid, .out_ready, .out_header,
    .out_last, .out_write, .out_word, .lb_valid, .lb_ready, .lb_first, .lb_last,
    .lb_write, .lb_word, .lb_rsp_valid, .lb_rsp_ready, .lb_rsp_data, .in_valid,
    .in_ready, .in_word, .in_perr, .cpu_in_valid, .cpu_in_ready, .cpu_in_word,
    .parity_irq, .src_route_pin, .fifo_enabled, .parity_check_on,
    .override_enable_flag, .routing_override_mask);
  roc_far far (.clk, .reset, .out_ready, .lb_ready, .lb_valid, .lb_first, .lb_write,
    .lb_rsp_valid, .lb_rsp_ready, .lb_rsp_data, .in_valid, .in_ready, .in_word,
    .in_perr, .cpu_in_ready);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic beat(input logic f, l, w, input logic [39:0] ad, input logic [63:0] d);
    int n;
    n = 0;
    @(negedge clk);
    pr_valid = 1;
    pr_first = f;
    pr_last = l;
    pr_write = w;
    pr_addr = ad;
    pr_data = d;
    @(posedge clk);
    while (pr_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      num_errors++;
      $display("[FAIL] %0t beat not taken", $time);
    end
  endtask
  task automatic idle(input int c);
    @(negedge clk);
    pr_valid = 0;
    repeat (c) @(negedge clk);
  endtask
  task automatic cwr(input logic [1:0] fn, input logic en, input logic [7:0] mk);
    beat(1, 0, 1, {4'h0, 4'h1, 4'h0, fn, en, 25'h0}, 64'h0);
    beat(0, 1, 0, 40'h0, {16'h0, mk, 40'h0});
    if (!fn[1]) begin
      mask_e = mk;
      flag_e = en;
    end
    idle(2);
  endtask
  task automatic crd(input logic [1:0] fn);
    beat(1, 1, 0, {4'h0, 4'h1, 4'h0, fn, 26'h0}, 64'h0);
    idle(0);
    chk(rsp_valid, 1);
    chk(rsp_data, 64'h0);
    idle(1);
  endtask
  function automatic logic [63:0] hdr(input logic [39:0] ad);
    logic [7:0] r;
    r = (8'h01 << (3'h4 + ad[39:38])) | (8'h01 << ad[37:36]);
    if ((flag_e && ad[35:32] == 4'hF) || (ad[35:32] == 4'h8 && ad[27])) r = mask_e;
    return {src_route_pin, 4'h0, r, ad};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (rsp_valid) rsp_n++;
    if (parity_irq) irq_n++;
    if (cpu_in_valid && cpu_in_ready) begin
      chk(cpu_in_word, 64'(dlv_n));
      dlv_n++;
    end
    if (out_valid && out_ready && out_header) begin
      chk(out_word, exp_q.pop_front());
      chk(out_last, !out_write);
    end
    if (lb_valid && lb_ready && lb_first) begin
      chk(lb_word[63:26], 38'h43);
      chk(lb_last, !lb_write);
    end
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(45));
    src_route_pin = 12'($urandom);
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 0;
    chk({fifo_enabled, parity_check_on, override_enable_flag}, 3'h6);
    chk(routing_override_mask, 8'h00);
    $display("reset test done");
    crd(2'h0);
    k = dlv_n;
    idle(5);
    chk(fifo_enabled, 0);
    chk(dlv_n, k);
    j = rsp_n;
    cwr(2'h1, 1, 8'($urandom));
    chk({fifo_enabled, parity_check_on, override_enable_flag}, 3'h3);
    chk(routing_override_mask, mask_e);
    crd(2'h1);
    chk(parity_check_on, 0);
    cwr(2'h0, 0, 8'($urandom));
    chk({fifo_enabled, parity_check_on, override_enable_flag}, 3'h4);
    chk(routing_override_mask, mask_e);
    chk(rsp_n, j + 1);
    k = irq_n;
    j = dlv_n;
    idle(10);
    chk(irq_n, k);
    chk(dlv_n > j, 1);
    cwr(2'h1, 0, mask_e);
    idle(10);
    chk(irq_n > k, 1);
    $display("control test done");
    for (e = 0; e < 2; e++) begin
      cwr(2'h0, e[0], 8'($urandom) | 8'h11);
      for (i = 0; i < 10; i++) begin
        a = 40'({$urandom, $urandom});
        a[35:32] = sels[$urandom_range(3)];
        exp_q.push_back(hdr(a));
        if (i[0]) begin
          beat(1, 1, 0, a, 64'h0);
        end else begin
          beat(1, 0, 1, a, 64'h0);
          for (k = 0; k < (e ? 8 : 1); k++) beat(0, k == (e ? 7 : 0), 0, a, 64'($urandom));
        end
      end
      idle(30);
    end
    cwr(2'h0, 0, mask_e);
    chk(override_enable_flag, 0);
    chk(exp_q.size(), 0);
    $display("routing test done");
    j = mask_e;
    beat(1, 1, 0, {4'h0, 4'h1, 4'h0, 2'h3, 26'h155}, 64'h0);
    idle(0);
    for (k = 0; k < 50 && rsp_valid !== 1'b1; k++) @(negedge clk);
    chk(rsp_data, 64'h5A5A_0000_1234_C3C3);
    cwr(2'h3, 1, ~mask_e);
    idle(4);
    chk(routing_override_mask, j);
    $display("local bus test done");
    finish_test();
  end
endmodule
